// ### logic/gcv_map.svh
// Register offsets, field positions, masks and codes of the pin control block
`ifndef GCV_MAP_SVH
`define GCV_MAP_SVH

`define GCV_OFS_OUT_LEVEL 8'h29
`define GCV_OFS_BIDIR_MON 8'h2A
`define GCV_OFS_IN_SEL_A 8'h2B
`define GCV_OFS_IN_SEL_B 8'h2C

`define GCV_RST_OUT_LEVEL 8'h00
`define GCV_RST_BIDIR_MON 8'h00
`define GCV_RST_IN_SEL_A 8'h00
`define GCV_RST_IN_SEL_B 8'h00

`define GCV_MASK_OUT_LEVEL 8'hF8
`define GCV_MASK_BIDIR_MON 8'h80
`define GCV_MASK_IN_SEL 8'h77

`define GCV_BIT_BIDIR_LEVEL 7
`define GCV_BIT_OUT_ONE_LEVEL 6
`define GCV_BIT_OUT_FOUR_LEVEL 3
`define GCV_BIT_BIDIR_SAMPLED 7
`define GCV_POS_SEL_HI 4
`define GCV_POS_SEL_LO 0

`define GCV_OUT_SEL_GPO 4'h1
`define GCV_BIDIR_SEL_GPO 4'h1
`define GCV_BIDIR_SEL_GPI 4'h2

`endif

// ### logic/gcv_pkg.sv
// Types shared by the pin control block
package gcv_pkg;

  typedef enum logic [2:0] {
    GCV_IN_OFF = 3'h0,
    GCV_IN_GPI = 3'h1,
    GCV_IN_MCLK = 3'h2,
    GCV_IN_CHAIN = 3'h3,
    GCV_IN_PDM_A = 3'h4,
    GCV_IN_PDM_B = 3'h5,
    GCV_IN_PDM_C = 3'h6,
    GCV_IN_PDM_D = 3'h7
  } gcv_in_func_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gcv_reg_req_t;

  typedef struct packed {
    logic master_clock;
    logic chain_serial_data_in;
    logic [3:0] pdm_data;
    logic [3:0] gpi_level;
  } gcv_routes_t;

  typedef struct packed {
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [7:0] output_level_values;
    logic [7:0] input_function_select_a;
    logic [7:0] input_function_select_b;
    logic [7:0] bidir_pin_monitor;
    logic [7:0] rdata;
    logic [3:0] out_level;
    logic [3:0] out_oe;
    logic bidir_out;
    logic bidir_oe;
    gcv_routes_t routes;
  } gcv_state_t;

endpackage

// ### logic/gcv_gpio.sv
// General-purpose pin control: output levels, bidir monitor, input routing
`timescale 1ns/10ps
`include "gcv_map.svh"
//
// Summary of operation
// - Bidir pin in output mode drives value bit 7, low for 0, high for 1.
// - Value bits 6..3 drive output pins one..four while each is a general output.
// - In input mode, monitor bit 7 returns sampled bidir level; read-only.
// - Select A bits 6-4 pick input pin one: off, general input, master clock.
// - Select A bits 2-0 pick input pin two with the same codes.
// - Code 3 routes the pin to the audio serial port as chain data input.
// - Codes 4..7 route the pin as PDM data for pairs 1-2, 3-4, 5-6, 7-8.
// - Select B bits 6-4 and 2-0 pick input pins three and four alike.
// - A value bit reaches its pin only while that pin's select holds code 1.
module gcv_gpio (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register access port
  input wire gcv_pkg::gcv_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Function selects of the output-capable pins, from the pin setup registers
  input wire logic [3:0] bidir_function_sel,
  input wire logic [3:0] out_one_function_sel,
  input wire logic [3:0] out_two_function_sel,
  input wire logic [3:0] out_three_function_sel,
  input wire logic [3:0] out_four_function_sel,
  // Bidirectional pin
  input wire logic bidir_pin_in,
  output logic bidir_pin_out,
  output logic bidir_pin_oe,
  // Output-only pins
  output logic out_pin_one,
  output logic out_pin_one_oe,
  output logic out_pin_two,
  output logic out_pin_two_oe,
  output logic out_pin_three,
  output logic out_pin_three_oe,
  output logic out_pin_four,
  output logic out_pin_four_oe,
  // Input-capable pins
  input wire logic in_pin_one,
  input wire logic in_pin_two,
  input wire logic in_pin_three,
  input wire logic in_pin_four,
  // Routed inputs to the rest of the device
  output gcv_pkg::gcv_routes_t routes
);

  gcv_pkg::gcv_state_t st;
  gcv_pkg::gcv_state_t next_st;

  // Function field of input pin n (0..3) from the two select registers
  function automatic logic [2:0] gcv_in_sel(
    input logic [7:0] sel_a,
    input logic [7:0] sel_b,
    input int unsigned n
  );
    logic [7:0] r;
    r = (n < 2) ? sel_a : sel_b;
    if ((n % 2) == 0) begin
      gcv_in_sel = r[`GCV_POS_SEL_HI +: 3];
    end else begin
      gcv_in_sel = r[`GCV_POS_SEL_LO +: 3];
    end
  endfunction

  // Lowest-numbered pin holding the code wins when several claim one function
  function automatic logic gcv_pick(
    input logic [11:0] sels,
    input logic [3:0] lvl,
    input gcv_pkg::gcv_in_func_t code
  );
    logic hit;
    logic v;
    hit = 1'b0;
    v = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!hit && sels[i*3 +: 3] == code) begin
        hit = 1'b1;
        v = lvl[i];
      end
    end
    gcv_pick = v;
  endfunction

  // Code 1 in a pin's setup field makes it a general output
  function automatic logic gcv_is_gpo(input logic [3:0] sel);
    gcv_is_gpo = (sel == `GCV_OUT_SEL_GPO);
  endfunction

  // Read view of one register; reserved bits and unmapped addresses give zero
  function automatic logic [7:0] gcv_read_data(
    input logic [7:0] addr,
    input gcv_pkg::gcv_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      `GCV_OFS_OUT_LEVEL: begin
        v = s.output_level_values & `GCV_MASK_OUT_LEVEL;
      end
      `GCV_OFS_BIDIR_MON: begin
        v = s.bidir_pin_monitor & `GCV_MASK_BIDIR_MON;
      end
      `GCV_OFS_IN_SEL_A: begin
        v = s.input_function_select_a & `GCV_MASK_IN_SEL;
      end
      `GCV_OFS_IN_SEL_B: begin
        v = s.input_function_select_b & `GCV_MASK_IN_SEL;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    gcv_read_data = v;
  endfunction

  logic [3:0] in_lvl;
  logic [11:0] sels;
  logic [3:0] out_sel_gpo;

  always_comb begin
    next_st = st;
    // Two-stage synchronisers; stage one feeds only stage two
    next_st.sync_a = {bidir_pin_in, in_pin_four, in_pin_three, in_pin_two, in_pin_one};
    next_st.sync_b = st.sync_a;
    in_lvl = st.sync_b[3:0];
    for (int i = 0; i < 4; i++) begin
      sels[i*3 +: 3] = gcv_in_sel(st.input_function_select_a, st.input_function_select_b, i);
    end

    // Register writes; reserved bits masked off
    if (reg_req.wr_en) begin
      case (reg_req.addr)
        `GCV_OFS_OUT_LEVEL: begin
          next_st.output_level_values = reg_req.wdata & `GCV_MASK_OUT_LEVEL;
        end
        `GCV_OFS_IN_SEL_A: begin
          next_st.input_function_select_a = reg_req.wdata & `GCV_MASK_IN_SEL;
        end
        `GCV_OFS_IN_SEL_B: begin
          next_st.input_function_select_b = reg_req.wdata & `GCV_MASK_IN_SEL;
        end
        `GCV_OFS_BIDIR_MON: begin
          // Monitor is read-only; a write here is dropped
        end
        default: begin
        end
      endcase
    end

    // Monitor has no write path; it reads zero outside input mode
    // Pin to register takes three edges: two synchroniser stages and this flop
    next_st.bidir_pin_monitor = `GCV_RST_BIDIR_MON;
    if (bidir_function_sel == `GCV_BIDIR_SEL_GPI) begin
      next_st.bidir_pin_monitor[`GCV_BIT_BIDIR_SAMPLED] = st.sync_b[4];
    end

    // Read data registered; a read beside a write returns the old value
    if (reg_req.rd_en) begin
      next_st.rdata = gcv_read_data(reg_req.addr, st);
    end

    // Pins are released, not pulled, when not a general output
    next_st.bidir_oe = (bidir_function_sel == `GCV_BIDIR_SEL_GPO);
    next_st.bidir_out = next_st.bidir_oe &
                        st.output_level_values[`GCV_BIT_BIDIR_LEVEL];

    // Value bits 6..3 belong to output pins one..four in turn
    out_sel_gpo[0] = gcv_is_gpo(out_one_function_sel);
    out_sel_gpo[1] = gcv_is_gpo(out_two_function_sel);
    out_sel_gpo[2] = gcv_is_gpo(out_three_function_sel);
    out_sel_gpo[3] = gcv_is_gpo(out_four_function_sel);
    for (int i = 0; i < 4; i++) begin
      next_st.out_oe[i] = out_sel_gpo[i];
      next_st.out_level[i] = out_sel_gpo[i] &
                             st.output_level_values[`GCV_BIT_OUT_ONE_LEVEL - i];
    end

    // Input routing; unclaimed routes and pins not coded 1 stay low
    for (int i = 0; i < 4; i++) begin
      next_st.routes.gpi_level[i] = (sels[i*3 +: 3] == gcv_pkg::GCV_IN_GPI) & in_lvl[i];
    end
    // Master clock passes the synchroniser, so it must stay well below sys_clk/2
    next_st.routes.master_clock = gcv_pick(sels, in_lvl, gcv_pkg::GCV_IN_MCLK);
    next_st.routes.chain_serial_data_in = gcv_pick(sels, in_lvl, gcv_pkg::GCV_IN_CHAIN);
    next_st.routes.pdm_data[0] = gcv_pick(sels, in_lvl, gcv_pkg::GCV_IN_PDM_A);
    next_st.routes.pdm_data[1] = gcv_pick(sels, in_lvl, gcv_pkg::GCV_IN_PDM_B);
    next_st.routes.pdm_data[2] = gcv_pick(sels, in_lvl, gcv_pkg::GCV_IN_PDM_C);
    next_st.routes.pdm_data[3] = gcv_pick(sels, in_lvl, gcv_pkg::GCV_IN_PDM_D);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.output_level_values <= `GCV_RST_OUT_LEVEL;
      st.input_function_select_a <= `GCV_RST_IN_SEL_A;
      st.input_function_select_b <= `GCV_RST_IN_SEL_B;
      st.bidir_pin_monitor <= `GCV_RST_BIDIR_MON;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign bidir_pin_out = st.bidir_out;
  assign bidir_pin_oe = st.bidir_oe;
  assign out_pin_one = st.out_level[0];
  assign out_pin_two = st.out_level[1];
  assign out_pin_three = st.out_level[2];
  assign out_pin_four = st.out_level[3];
  assign out_pin_one_oe = st.out_oe[0];
  assign out_pin_two_oe = st.out_oe[1];
  assign out_pin_three_oe = st.out_oe[2];
  assign out_pin_four_oe = st.out_oe[3];
  assign routes = st.routes;

endmodule

// ### dv/gcv_gpio_properties.sv
// Port-level checks of the pin control block
`timescale 1ns/10ps
module gcv_gpio_properties (
  // Clock, reset and register port
  input logic sys_clk,
  input logic rst_n,
  input gcv_pkg::gcv_reg_req_t reg_req,
  input logic [7:0] reg_rdata,
  // Pin selects and pins
  input logic [3:0] bidir_function_sel,
  input logic [3:0] out_one_function_sel,
  input logic [3:0] out_two_function_sel,
  input logic bidir_pin_out,
  input logic out_pin_one,
  input logic out_pin_two_oe,
  input logic out_pin_three,
  input logic out_pin_three_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_bidir_level_drive: assert property (reg_req.wr_en && reg_req.addr == 8'h29 &&
    bidir_function_sel == 4'h1 ##1 bidir_function_sel == 4'h1 |=>
    bidir_pin_out == $past(reg_req.wdata[7], 2)) else $error("bidir level wrong");
  chk_out_one_drive: assert property (reg_req.wr_en && reg_req.addr == 8'h29 &&
    out_one_function_sel == 4'h1 ##1 out_one_function_sel == 4'h1 |=>
    out_pin_one == $past(reg_req.wdata[6], 2)) else $error("pin one level wrong");
  chk_out_two_enable: assert property ($past(rst_n) |->
    out_pin_two_oe == ($past(out_two_function_sel) == 4'h1)) else $error("pin two enable wrong");
  chk_disabled_low: assert property (!out_pin_three_oe |-> !out_pin_three)
    else $error("disabled pin not low");
  chk_sel_reserved_zero: assert property (reg_req.rd_en &&
    reg_req.addr inside {8'h2B, 8'h2C} |=>
    reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0) else $error("select reserved bit set");
  chk_mon_reserved_zero: assert property (reg_req.rd_en && reg_req.addr == 8'h2A
    |=> reg_rdata[6:0] == 7'h00) else $error("monitor reserved bits set");
  chk_unmapped_zero: assert property (reg_req.rd_en &&
    !(reg_req.addr inside {[8'h29:8'h2C]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_value_readback: assert property (reg_req.wr_en && reg_req.addr == 8'h29 ##1
    reg_req.rd_en && !reg_req.wr_en && reg_req.addr == 8'h29 |=>
    reg_rdata == ($past(reg_req.wdata, 2) & 8'hF8)) else $error("value readback wrong");
endmodule

// ### dv/gcv_gpio_tb_top.sv
// Self-checking bench for the pin control block
`timescale 1ns/10ps
module gcv_gpio_tb_top;
  logic sys_clk = 0;
  logic rst_n = 0;
  gcv_pkg::gcv_reg_req_t req = '0;
  logic [3:0] bsel = 0, s1 = 0, s2 = 0, s3 = 0, s4 = 0, inp = 0;
  logic bin = 0, pend = 0;
  logic [7:0] rdata;
  wire [9:0] pn;
  gcv_pkg::gcv_routes_t routes;
  logic [15:0] expq[$];
  logic [7:0] ad[4] = '{8'h29, 8'h2B, 8'h2C, 8'h2A};
  logic [7:0] mk[4] = '{8'hF8, 8'h77, 8'h77, 8'h00};
  int miscompares = 0, n_compared = 0;
  gcv_gpio dut_u (.sys_clk, .rst_n, .reg_req(req), .reg_rdata(rdata), .bidir_function_sel(bsel),
    .out_one_function_sel(s1), .out_two_function_sel(s2), .out_three_function_sel(s3),
    .out_four_function_sel(s4), .bidir_pin_in(bin), .bidir_pin_out(pn[9]), .bidir_pin_oe(pn[8]),
    .out_pin_one(pn[7]), .out_pin_one_oe(pn[6]), .out_pin_two(pn[5]), .out_pin_two_oe(pn[4]),
    .out_pin_three(pn[3]), .out_pin_three_oe(pn[2]), .out_pin_four(pn[1]),
    .out_pin_four_oe(pn[0]), .in_pin_one(inp[0]), .in_pin_two(inp[1]), .in_pin_three(inp[2]),
    .in_pin_four(inp[3]), .routes);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    req <= '{w, r, a, d};
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    expq.push_back({8'h00, e});
    op(0, 1, a, 8'h00);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Read data shows one edge after the read is taken
  always @(posedge sys_clk) begin
    if (pend) chk({8'h00, rdata}, expq.pop_front());
    pend <= req.rd_en;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [7:0] d;
    logic [31:0] r;
    logic v;
    logic [15:0] e;
    gcv_pkg::gcv_routes_t ex;
    void'($urandom(44724));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1;
    foreach (ad[i]) rd(ad[i], 8'h00);
    rd(8'h2D, 8'h00);
    rd(8'hFF, 8'h00);
    $display("test reset values done");
    repeat (8) foreach (ad[i]) begin
      d = 8'($urandom);
      op(1, 0, ad[i], d);
      rd(ad[i], d & mk[i]);
    end
    $display("test register access done");
    repeat (8) begin
      d = 8'($urandom);
      r = $urandom;
      op(1, 0, 8'h29, d);
      {s4, s3, s2, s1, bsel} <= {2'h0, r[9:8], 2'h0, r[7:6], 2'h0, r[5:4],
                                 2'h0, r[3:2], 2'h0, r[1:0]};
      op(0, 0, 8'h00, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1;
      e = '0;
      for (int k = 0; k < 5; k++) begin
        e = {e[13:0], d[7 - k] & (r[2 * k +: 2] == 2'h1), r[2 * k +: 2] == 2'h1};
      end
      chk({6'h00, pn}, e);
    end
    $display("test output pins done");
    @(posedge sys_clk);
    bsel <= 4'h2;
    for (int i = 0; i < 4; i++) begin
      v = 1'($urandom);
      bin <= v;
      repeat (5) @(posedge sys_clk);
      rd(8'h2A, {v, 7'h00});
      op(0, 0, 8'h00, 8'h00);
    end
    $display("test bidir monitor done");
    for (int p = 0; p < 4; p++) for (int c = 0; c < 8; c++) begin
      v = 1'($urandom);
      d = 8'(c) << (p[0] ? 0 : 4);
      op(1, 0, 8'h2B, p < 2 ? d : 8'h00);
      op(1, 0, 8'h2C, p < 2 ? 8'h00 : d);
      inp <= 4'(v) << p;
      op(0, 0, 8'h00, 8'h00);
      repeat (4) @(posedge sys_clk);
      #1;
      ex = '0;
      if (c == 1) ex.gpi_level[p] = v;
      if (c == 2) ex.master_clock = v;
      if (c == 3) ex.chain_serial_data_in = v;
      if (c > 3) ex.pdm_data[c - 4] = v;
      chk(16'(routes), 16'(ex));
    end
    $display("test input routing done");
    op(0, 0, 8'h00, 8'h00);
    repeat (3) @(posedge sys_clk);
    end_of_test();
  end
endmodule
bind gcv_gpio gcv_gpio_properties chk_u (.sys_clk, .rst_n, .reg_req, .reg_rdata,
  .bidir_function_sel, .out_one_function_sel, .out_two_function_sel, .bidir_pin_out,
  .out_pin_one, .out_pin_two_oe, .out_pin_three, .out_pin_three_oe);
